/* hdl/droop_input_sync.sv */
// three-stage synchroniser with agreement filter for a comparator level
`timescale 1ns/10ps
module droop_input_sync (
  input wire logic clk,
  input wire logic reset,
  input wire logic asyncIn,
  output logic syncOut
);

  logic [droop_monitor_pkg::SYNC_STAGES-1:0] stage_q;
  logic syncOut_q;

  always_ff @(posedge clk) begin
    if (reset) begin
      stage_q <= '0;
    end else begin
      stage_q <= {stage_q[1:0], asyncIn};
    end
  end

  // stage 0 feeds only stage 1; a change counts once stages 1 and 2 agree
  always_ff @(posedge clk) begin
    if (reset) begin
      syncOut_q <= 1'b0;
    end else if (stage_q[1] == stage_q[2]) begin
      syncOut_q <= stage_q[2];
    end
  end

  assign syncOut = syncOut_q;

endmodule

/* hdl/droop_monitor_pkg.sv */
// shared constants for the supply droop monitor control block
package droop_monitor_pkg;

  // ****************************************
  // register map (byte addresses)
  // ****************************************
  localparam logic [3:0] CTRL_STATUS_A_OFFSET = 4'h0;
  localparam logic [3:0] CTRL_STATUS_B_OFFSET = 4'h4;
  localparam logic [3:0] CTRL_STATUS_C_OFFSET = 4'h8;

  // ****************************************
  // status-control A fields
  // ****************************************
  localparam int DETECT_FLAG_BIT = 7;
  localparam int DETECT_ACK_BIT = 6;
  localparam int IRQ_ENABLE_BIT = 5;
  localparam int RESET_ENABLE_BIT = 4;
  localparam int STOP_ENABLE_BIT = 3;
  localparam int MONITOR_ENABLE_BIT = 2;
  localparam int REF_BUFFER_BIT = 0;

  // ****************************************
  // status-control B / C fields
  // ****************************************
  localparam int WARNING_FLAG_BIT = 7;
  localparam int WARNING_ACK_BIT = 6;
  localparam int DETECT_LEVEL_BIT = 5;
  localparam int WARNING_LEVEL_BIT = 4;
  localparam int POWERDOWN_FLAG_BIT = 4;

  // ****************************************
  // reset values and answers
  // ****************************************
  localparam logic [7:0] CTRL_A_RESET = 8'h1C;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam int SYNC_STAGES = 3;

endpackage

/* hdl/supply_droop_monitor_ctrl.sv */
// supply droop monitor control and status logic with AXI4-Lite slave
// How it works
// - sticky detect flag set on detect comparator
// - writing detect ack one clears flag
// - interrupt only while irq enable set
// - system reset only while reset enable set
// - monitor enable gates flag, irq, reset
// - stop enable keeps monitor alive in stop
// - sticky warning flag set on warning comparator
// - writing warning ack one clears warning
// - detect level select picks high/low trip
// - warning level select picks high/low trip
// - alternate layout: powerdown flag at bit 4
`timescale 1ns/10ps
module supply_droop_monitor_ctrl #(
  parameter bit WARNING_IN_THIRD_REG = 1'b0
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [3:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [3:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic detectBelowHigh,
  input wire logic detectBelowLow,
  input wire logic warningBelowHigh,
  input wire logic warningBelowLow,
  input wire logic stopMode,
  input wire logic powerdownWake,
  output logic droopIrq,
  output logic droopReset,
  output logic monitorActive,
  output logic detectLevelHigh,
  output logic warningLevelHigh,
  output logic referenceBufferEnable
);

  // ****************************************
  // comparator synchronisers
  // ****************************************
  logic detHighS, detLowS, warnHighS, warnLowS, pdWakeS;

  droop_input_sync syncDetHigh (.clk(clk), .reset(reset),
    .asyncIn(detectBelowHigh), .syncOut(detHighS));
  droop_input_sync syncDetLow (.clk(clk), .reset(reset),
    .asyncIn(detectBelowLow), .syncOut(detLowS));
  droop_input_sync syncWarnHigh (.clk(clk), .reset(reset),
    .asyncIn(warningBelowHigh), .syncOut(warnHighS));
  droop_input_sync syncWarnLow (.clk(clk), .reset(reset),
    .asyncIn(warningBelowLow), .syncOut(warnLowS));
  droop_input_sync syncPdWake (.clk(clk), .reset(reset),
    .asyncIn(powerdownWake), .syncOut(pdWakeS));

  // ****************************************
  // control state
  // ****************************************
  logic irqEnable_q, resetEnable_q, stopEnable_q, monitorEnable_q;
  logic refBuffer_q, detectLevel_q, warningLevel_q;
  logic detectFlag_q, warningFlag_q, powerdownFlag_q;
  logic detectAckPulse, warningAckPulse, monitorRun;
  logic detectBelow, warningBelow;

  // ****************************************
  // bus slave
  // ****************************************
  logic awHeld_q, wHeld_q;
  logic [3:0] awAddr_q;
  logic [31:0] wData_q;
  logic [3:0] wStrb_q;
  logic writeFire;

  assign writeFire = awHeld_q && wHeld_q && !bvalid;

  always_ff @(posedge clk) begin
    if (reset) begin
      awHeld_q <= 1'b0;
      awAddr_q <= 4'h0;
    end else if (awvalid && awready) begin
      awHeld_q <= 1'b1;
      awAddr_q <= awaddr;
    end else if (writeFire) begin
      awHeld_q <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      wHeld_q <= 1'b0;
      wData_q <= 32'h0000_0000;
      wStrb_q <= 4'h0;
    end else if (wvalid && wready) begin
      wHeld_q <= 1'b1;
      wData_q <= wdata;
      wStrb_q <= wstrb;
    end else if (writeFire) begin
      wHeld_q <= 1'b0;
    end
  end

  // readies are registered: each drops on the same edge that its item lands
  always_ff @(posedge clk) begin
    if (reset) begin
      awready <= 1'b0;
      wready <= 1'b0;
    end else begin
      awready <= !awHeld_q && !(awvalid && awready) && !bvalid;
      wready <= !wHeld_q && !(wvalid && wready) && !bvalid;
    end
  end

  logic addrMapped;
  always_comb begin
    addrMapped = (awAddr_q == droop_monitor_pkg::CTRL_STATUS_A_OFFSET) ||
      (awAddr_q == droop_monitor_pkg::CTRL_STATUS_B_OFFSET) ||
      (WARNING_IN_THIRD_REG &&
       awAddr_q == droop_monitor_pkg::CTRL_STATUS_C_OFFSET);
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      bvalid <= 1'b0;
      bresp <= droop_monitor_pkg::RESP_OKAY;
    end else if (writeFire) begin
      bvalid <= 1'b1;
      bresp <= addrMapped ? droop_monitor_pkg::RESP_OKAY
                          : droop_monitor_pkg::RESP_SLVERR;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  logic writeA, writeB, writeC, laneLow;
  assign laneLow = wStrb_q[0];
  assign writeA = writeFire && laneLow &&
    awAddr_q == droop_monitor_pkg::CTRL_STATUS_A_OFFSET;
  assign writeB = writeFire && laneLow &&
    awAddr_q == droop_monitor_pkg::CTRL_STATUS_B_OFFSET;
  assign writeC = writeFire && laneLow && WARNING_IN_THIRD_REG &&
    awAddr_q == droop_monitor_pkg::CTRL_STATUS_C_OFFSET;

  // ****************************************
  // control register writes
  // ****************************************
  always_ff @(posedge clk) begin
    if (reset) begin
      irqEnable_q <= droop_monitor_pkg::CTRL_A_RESET[5];
      resetEnable_q <= droop_monitor_pkg::CTRL_A_RESET[4];
      stopEnable_q <= droop_monitor_pkg::CTRL_A_RESET[3];
      monitorEnable_q <= droop_monitor_pkg::CTRL_A_RESET[2];
      refBuffer_q <= droop_monitor_pkg::CTRL_A_RESET[0];
    end else if (writeA) begin
      irqEnable_q <= wData_q[droop_monitor_pkg::IRQ_ENABLE_BIT];
      resetEnable_q <= wData_q[droop_monitor_pkg::RESET_ENABLE_BIT];
      stopEnable_q <= wData_q[droop_monitor_pkg::STOP_ENABLE_BIT];
      monitorEnable_q <= wData_q[droop_monitor_pkg::MONITOR_ENABLE_BIT];
      refBuffer_q <= wData_q[droop_monitor_pkg::REF_BUFFER_BIT];
    end
  end

  logic warnRegWrite;
  assign warnRegWrite = WARNING_IN_THIRD_REG ? writeC : writeB;

  always_ff @(posedge clk) begin
    if (reset) begin
      detectLevel_q <= 1'b0;
    end else if (writeB) begin
      detectLevel_q <= wData_q[droop_monitor_pkg::DETECT_LEVEL_BIT];
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      warningLevel_q <= 1'b0;
    end else if (warnRegWrite) begin
      warningLevel_q <= wData_q[droop_monitor_pkg::WARNING_LEVEL_BIT];
    end
  end

  // ack bits are strobes only, never stored
  assign detectAckPulse = writeA &&
    wData_q[droop_monitor_pkg::DETECT_ACK_BIT];
  assign warningAckPulse = warnRegWrite &&
    wData_q[droop_monitor_pkg::WARNING_ACK_BIT];

  // ****************************************
  // detection
  // ****************************************
  // in stop mode the monitor runs only if stop enable is set
  assign monitorRun = monitorEnable_q && (!stopMode || stopEnable_q);
  assign detectBelow = detectLevel_q ? detHighS : detLowS;
  assign warningBelow = warningLevel_q ? warnHighS : warnLowS;

  // set wins over a same-cycle ack so no droop is lost
  always_ff @(posedge clk) begin
    if (reset) begin
      detectFlag_q <= 1'b0;
    end else if (monitorRun && detectBelow) begin
      detectFlag_q <= 1'b1;
    end else if (detectAckPulse) begin
      detectFlag_q <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      warningFlag_q <= 1'b0;
    end else if (monitorRun && warningBelow) begin
      warningFlag_q <= 1'b1;
    end else if (warningAckPulse) begin
      warningFlag_q <= 1'b0;
    end
  end

  // powerdown flag exists only in the three-register layout
  always_ff @(posedge clk) begin
    if (reset) begin
      powerdownFlag_q <= 1'b0;
    end else if (WARNING_IN_THIRD_REG && pdWakeS) begin
      powerdownFlag_q <= 1'b1;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  always_ff @(posedge clk) begin
    if (reset) begin
      droopIrq <= 1'b0;
      droopReset <= 1'b0;
      monitorActive <= 1'b0;
      detectLevelHigh <= 1'b0;
      warningLevelHigh <= 1'b0;
      referenceBufferEnable <= 1'b0;
    end else begin
      droopIrq <= detectFlag_q && irqEnable_q && monitorEnable_q;
      droopReset <= monitorRun && detectBelow && resetEnable_q;
      monitorActive <= monitorRun;
      detectLevelHigh <= detectLevel_q;
      warningLevelHigh <= warningLevel_q;
      referenceBufferEnable <= refBuffer_q;
    end
  end

  // ****************************************
  // read channel
  // ****************************************
  logic [7:0] readByte;
  logic readMapped;
  always_comb begin
    readByte = 8'h00;
    readMapped = 1'b1;
    case (araddr)
      droop_monitor_pkg::CTRL_STATUS_A_OFFSET: begin
        readByte = {detectFlag_q, 1'b0, irqEnable_q, resetEnable_q,
                    stopEnable_q, monitorEnable_q, 1'b0, refBuffer_q};
      end
      droop_monitor_pkg::CTRL_STATUS_B_OFFSET: begin
        if (WARNING_IN_THIRD_REG) begin
          readByte = {2'h0, detectLevel_q, powerdownFlag_q, 4'h0};
        end else begin
          readByte = {warningFlag_q, 1'b0, detectLevel_q, warningLevel_q,
                      4'h0};
        end
      end
      droop_monitor_pkg::CTRL_STATUS_C_OFFSET: begin
        readMapped = WARNING_IN_THIRD_REG;
        if (WARNING_IN_THIRD_REG) begin
          readByte = {warningFlag_q, 2'h0, warningLevel_q, 4'h0};
        end
      end
      default: begin
        readMapped = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      arready <= 1'b0;
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= droop_monitor_pkg::RESP_OKAY;
    end else if (arvalid && arready) begin
      arready <= 1'b0;
      rvalid <= 1'b1;
      rdata <= {24'h00_0000, readByte};
      rresp <= readMapped ? droop_monitor_pkg::RESP_OKAY
                          : droop_monitor_pkg::RESP_SLVERR;
    end else if (rvalid) begin
      if (rready) begin
        rvalid <= 1'b0;
      end
    end else begin
      arready <= 1'b1;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  a_detect_sets: assert property (@(posedge clk) disable iff (reset)
    monitorRun && detectBelow |=> detectFlag_q)
    else $error("detect flag not set on droop");
  a_detect_ack_clears: assert property (@(posedge clk) disable iff (reset)
    detectAckPulse && !(monitorRun && detectBelow) |=> !detectFlag_q)
    else $error("detect ack did not clear flag");
  a_irq_gated: assert property (@(posedge clk) disable iff (reset)
    droopIrq |-> $past(irqEnable_q) && $past(detectFlag_q))
    else $error("interrupt without enable or flag");
  a_reset_gated: assert property (@(posedge clk) disable iff (reset)
    droopReset |-> $past(resetEnable_q) && $past(monitorEnable_q))
    else $error("reset without enable");
  a_monitor_off: assert property (@(posedge clk) disable iff (reset)
    !monitorEnable_q && !detectFlag_q |=> !detectFlag_q)
    else $error("flag set while monitor off");
  a_stop_gate: assert property (@(posedge clk) disable iff (reset)
    stopMode && !stopEnable_q |=> !monitorActive)
    else $error("monitor active in stop without enable");
  a_warning_sets: assert property (@(posedge clk) disable iff (reset)
    monitorRun && warningBelow |=> warningFlag_q)
    else $error("warning flag not set");
  a_warning_ack_clears: assert property (@(posedge clk) disable iff (reset)
    warningAckPulse && !(monitorRun && warningBelow) |=> !warningFlag_q)
    else $error("warning ack did not clear flag");
  a_ack_reads_zero: assert property (@(posedge clk) disable iff (reset)
    rvalid |-> !rdata[droop_monitor_pkg::DETECT_ACK_BIT])
    else $error("ack bit read as one");

endmodule

/* sim/test_supply_droop_monitor_ctrl.sv */
// self-checking bench for the supply droop monitor control block
`timescale 1ns/10ps
module test_supply_droop_monitor_ctrl;
  logic clk, reset, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  logic [3:0] awaddr, araddr, wstrb;
  logic [31:0] wdata, rdata;
  logic [31:0] rdataAlt, rdataAltSeen;
  logic [1:0] bresp, rresp;
  logic detectBelowHigh, detectBelowLow, warningBelowHigh, warningBelowLow;
  logic stopMode, powerdownWake, droopIrq, droopReset, monitorActive;
  logic detectLevelHigh, warningLevelHigh, referenceBufferEnable;
  int n_fail = 0;
  int checked = 0;
  localparam logic [3:0] A = droop_monitor_pkg::CTRL_STATUS_A_OFFSET;
  localparam logic [3:0] B = droop_monitor_pkg::CTRL_STATUS_B_OFFSET;

  supply_droop_monitor_ctrl DUT (.clk(clk), .reset(reset),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .detectBelowHigh(detectBelowHigh), .detectBelowLow(detectBelowLow),
    .warningBelowHigh(warningBelowHigh), .warningBelowLow(warningBelowLow),
    .stopMode(stopMode), .powerdownWake(powerdownWake),
    .droopIrq(droopIrq), .droopReset(droopReset),
    .monitorActive(monitorActive), .detectLevelHigh(detectLevelHigh),
    .warningLevelHigh(warningLevelHigh),
    .referenceBufferEnable(referenceBufferEnable));

  // three-register layout shadows every bus call in lockstep
  supply_droop_monitor_ctrl #(.WARNING_IN_THIRD_REG(1'b1)) altLayout (
    .clk(clk), .reset(reset),
    .awaddr(awaddr), .awvalid(awvalid), .awready(),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(),
    .bresp(), .bvalid(), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(),
    .rdata(rdataAlt), .rresp(), .rvalid(), .rready(rready),
    .detectBelowHigh(detectBelowHigh), .detectBelowLow(detectBelowLow),
    .warningBelowHigh(warningBelowHigh), .warningBelowLow(warningBelowLow),
    .stopMode(stopMode), .powerdownWake(powerdownWake),
    .droopIrq(), .droopReset(), .monitorActive(), .detectLevelHigh(),
    .warningLevelHigh(), .referenceBufferEnable());

  // ****************************************
  // clock, reset and watchdog
  // ****************************************
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  initial begin
    // the whole sequence needs well under 2000 cycles
    #50000;
    n_fail++;
    $display("watchdog expired at %0t", $time);
    print_verdict();
  end

  // ****************************************
  // bus and compare tasks
  // ****************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED at %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  // responses are sampled at the edge, before that edge's updates land
  task automatic wrResp(input logic [3:0] a, input logic [7:0] d,
                        input logic [1:0] expResp);
    awaddr <= a;
    wdata <= {24'h000000, d};
    wstrb <= 4'hF;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    chk({30'h0, bresp}, {30'h0, expResp});
    bready <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rdResp(input logic [3:0] a, input logic [31:0] exp,
                        input logic [1:0] expResp);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rdataAltSeen = rdataAlt;
    chk(rdata, exp);
    chk({30'h0, rresp}, {30'h0, expResp});
    rready <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    wrResp(a, d, droop_monitor_pkg::RESP_OKAY);
  endtask

  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    rdResp(a, {24'h000000, exp}, droop_monitor_pkg::RESP_OKAY);
  endtask

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // ****************************************
  // test sequence
  // ****************************************
  initial begin
    reset = 1'b1;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    awaddr = 4'h0;
    araddr = 4'h0;
    wdata = 32'h00000000;
    wstrb = 4'h0;
    {detectBelowHigh, detectBelowLow, warningBelowHigh} = 3'h0;
    {warningBelowLow, stopMode, powerdownWake} = 3'h0;
    repeat (12) @(posedge clk);
    reset <= 1'b0;
    cyc(2);
    rd(A, droop_monitor_pkg::CTRL_A_RESET);
    rd(B, 8'h00);
    rdResp(4'hC, 32'h00000000, droop_monitor_pkg::RESP_SLVERR);
    wrResp(4'hC, 8'hFF, droop_monitor_pkg::RESP_SLVERR);
    rd(A, 8'h1C);
    $display("test reset and map done");
    // high comparator ignored while low trip selected
    detectBelowHigh <= 1'b1;
    cyc(8);
    rd(A, 8'h1C);
    chk(droopReset, 1'b0);
    wr(B, 8'h20);
    cyc(2);
    chk(detectLevelHigh, 1'b1);
    cyc(8);
    rd(A, 8'h9C);
    chk(droopReset, 1'b1);
    chk(droopIrq, 1'b0);
    wr(A, 8'h2C);
    cyc(3);
    rd(A, 8'hAC);
    chk(droopIrq, 1'b1);
    chk(droopReset, 1'b0);
    wr(A, 8'h0C);
    cyc(3);
    chk(droopIrq, 1'b0);
    detectBelowHigh <= 1'b0;
    cyc(8);
    wr(A, 8'h6C);
    cyc(3);
    rd(A, 8'h2C);
    chk(droopIrq, 1'b0);
    $display("test detect flag done");
    // monitor off, then stop mode with and without stop enable
    wr(A, 8'h39);
    detectBelowHigh <= 1'b1;
    cyc(8);
    rd(A, 8'h39);
    chk({droopIrq, droopReset, monitorActive}, 3'h0);
    chk(referenceBufferEnable, 1'b1);
    stopMode <= 1'b1;
    wr(A, 8'h34);
    cyc(8);
    rd(A, 8'h34);
    chk({monitorActive, droopReset}, 2'h0);
    wr(A, 8'h3C);
    cyc(8);
    chk(monitorActive, 1'b1);
    rd(A, 8'hBC);
    chk({droopIrq, droopReset}, 2'h3);
    stopMode <= 1'b0;
    detectBelowHigh <= 1'b0;
    // low trip comparator raises the flag again after ack
    wr(B, 8'h00);
    cyc(8);
    wr(A, 8'h7C);
    rd(A, 8'h3C);
    detectBelowLow <= 1'b1;
    cyc(8);
    rd(A, 8'hBC);
    detectBelowLow <= 1'b0;
    cyc(8);
    wr(A, 8'h7C);
    rd(A, 8'h3C);
    $display("test enables done");
    // warning flag on both trip points
    warningBelowHigh <= 1'b1;
    cyc(8);
    rd(B, 8'h00);
    wr(B, 8'h10);
    cyc(8);
    chk(warningLevelHigh, 1'b1);
    rd(B, 8'h90);
    rd(A, 8'h3C);
    wr(B, 8'h10);
    rd(B, 8'h90);
    warningBelowHigh <= 1'b0;
    cyc(8);
    wr(B, 8'h50);
    rd(B, 8'h10);
    wr(B, 8'h00);
    warningBelowLow <= 1'b1;
    cyc(8);
    rd(B, 8'h80);
    warningBelowLow <= 1'b0;
    cyc(8);
    wr(B, 8'h40);
    rd(B, 8'h00);
    $display("test warning flag done");
    // wake only matters in the three-register layout
    powerdownWake <= 1'b1;
    cyc(8);
    rd(B, 8'h00);
    chk(rdataAltSeen, 32'h00000010);
    rdResp(droop_monitor_pkg::CTRL_STATUS_C_OFFSET, 32'h00000000,
           droop_monitor_pkg::RESP_SLVERR);
    chk(rdataAltSeen, 32'h00000080);
    wrResp(droop_monitor_pkg::CTRL_STATUS_C_OFFSET, 8'h40,
           droop_monitor_pkg::RESP_SLVERR);
    rdResp(droop_monitor_pkg::CTRL_STATUS_C_OFFSET, 32'h00000000,
           droop_monitor_pkg::RESP_SLVERR);
    chk(rdataAltSeen, 32'h00000000);
    $display("test alternate layout done");
    print_verdict();
  end
endmodule
